//--- rtl/pmt_divider.sv
// clearable event divider used as prescaler and postscaler
module pmt_divider #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // control
  input  wire logic         clr,
  input  wire logic         en,
  input  wire logic [W-1:0] term,
  // state
  output logic      [W-1:0] cnt,
  output logic              tick
);

  // one tick per term+1 enabled events
  assign tick = en && !clr && (cnt == term);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= '0;
    else if (clr || tick)
      cnt <= '0;
    else if (en)
      cnt <= cnt + W'(1);
  end

endmodule

//--- rtl/pmt_pkg.sv
// shared constants and types of the period match timer
package pmt_pkg;

  // apb register byte offsets
  localparam logic [7:0] PMT_ADDR_COUNT  = 8'h00;
  localparam logic [7:0] PMT_ADDR_PERIOD = 8'h04;
  localparam logic [7:0] PMT_ADDR_CTRL   = 8'h08;
  localparam logic [7:0] PMT_ADDR_FLAG   = 8'h0C;
  localparam logic [7:0] PMT_ADDR_ENABLE = 8'h10;
  localparam logic [7:0] PMT_ADDR_GLOBAL = 8'h14;

  // register field positions
  localparam int PMT_CTRL_PRE_LSB  = 0;
  localparam int PMT_CTRL_POST_LSB = 3;
  localparam int PMT_FLAG_BIT      = 0;
  localparam int PMT_ENABLE_BIT    = 0;
  localparam int PMT_GIE_BIT       = 0;
  localparam int PMT_SPI_SEL_BIT   = 1;

  // reset values
  localparam logic [7:0] PMT_COUNT_RST  = 8'h00;
  localparam logic [7:0] PMT_PERIOD_RST = 8'hFF;

  // prescale select codes and divider terminal values
  localparam logic [1:0] PMT_PRE_DIV1  = 2'h0;
  localparam logic [1:0] PMT_PRE_DIV4  = 2'h1;
  localparam logic [3:0] PMT_TERM_DIV1  = 4'h0;
  localparam logic [3:0] PMT_TERM_DIV4  = 4'h3;
  localparam logic [3:0] PMT_TERM_DIV16 = 4'hF;

  // instruction clock is the core clock divided by four
  localparam int         PMT_INST_DIV  = 4;
  localparam logic [1:0] PMT_INST_LAST = 2'(PMT_INST_DIV - 1);

  typedef struct packed {
    logic [3:0] postscale_select;
    logic [1:0] prescale_select;
  } pmt_ctrl_s;

  localparam pmt_ctrl_s PMT_CTRL_RST = '0;

endpackage

//--- rtl/pmt_timer.sv
// period match timer with apb register access
//
// Added by the designer: the register addresses and the APB slave port.
module pmt_timer
(
  // apb slave
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // device state
  input  wire logic         sys_reset,
  input  wire logic         sleep,
  // timer outputs
  output logic              match_out,
  output logic              spi_shift_clk,
  output logic              irq
);
  import pmt_pkg::*;

  logic [7:0]  count_r;
  logic [7:0]  period_r;
  pmt_ctrl_s   ctrl_r;
  logic        flag_r;
  logic        enable_r;
  logic        gie_r;
  logic        spi_sel_r;
  logic [1:0]  inst_div_r;
  logic        match_out_r;
  logic        spi_clk_r;
  logic        irq_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  logic        access;
  logic        wr_en;
  logic        rd_load;
  logic        wr_count;
  logic        wr_ctrl;
  logic        div_clr;
  logic        inst_tick;
  logic [3:0]  pre_term;
  logic [3:0]  pre_cnt;
  logic        tmr_tick;
  logic [3:0]  post_cnt;
  logic        post_evt;
  logic        match_evt;
  logic        addr_ok;
  logic [31:0] rd_mux;

  // apb decode; one wait state so every bus output is a flop
  assign access   = psel && penable;
  assign rd_load  = access && !pready_r;
  assign wr_en    = access && pready_r && pwrite;
  assign wr_count = wr_en && (paddr == PMT_ADDR_COUNT);
  assign wr_ctrl  = wr_en && (paddr == PMT_ADDR_CTRL);
  assign div_clr  = wr_count || wr_ctrl || sys_reset;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_mux  = '0;
    unique case (paddr)
      PMT_ADDR_COUNT:  rd_mux[7:0] = count_r;
      PMT_ADDR_PERIOD: rd_mux[7:0] = period_r;
      PMT_ADDR_CTRL:   rd_mux[6:0] = {ctrl_r.postscale_select, 1'b0,
                                      ctrl_r.prescale_select};
      PMT_ADDR_FLAG:   rd_mux[PMT_FLAG_BIT] = flag_r;
      PMT_ADDR_ENABLE: rd_mux[PMT_ENABLE_BIT] = enable_r;
      PMT_ADDR_GLOBAL: rd_mux[PMT_SPI_SEL_BIT:PMT_GIE_BIT] = {spi_sel_r, gie_r};
      default:         addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= rd_load;
      pslverr_r <= rd_load && !addr_ok;
      if (rd_load)
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // instruction clock enable; sleep freezes it so nothing counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      inst_div_r <= '0;
    else if (sys_reset)
      inst_div_r <= '0;
    else if (!sleep)
      inst_div_r <= inst_div_r + 2'h1;
  end

  assign inst_tick = !sleep && (inst_div_r == PMT_INST_LAST);

  always_comb
  begin
    unique case (ctrl_r.prescale_select)
      PMT_PRE_DIV1: pre_term = PMT_TERM_DIV1;
      PMT_PRE_DIV4: pre_term = PMT_TERM_DIV4;
      default:      pre_term = PMT_TERM_DIV16;
    endcase
  end

  pmt_divider #(.W(4)) u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (div_clr),
    .en      (inst_tick),
    .term    (pre_term),
    .cnt     (pre_cnt),
    .tick    (tmr_tick)
  );

  assign match_evt = tmr_tick && (count_r == period_r);

  pmt_divider #(.W(4)) u_postscaler (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (div_clr),
    .en      (match_evt),
    .term    (ctrl_r.postscale_select),
    .cnt     (post_cnt),
    .tick    (post_evt)
  );

  // counter: a bus write wins over counting in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= PMT_COUNT_RST;
    else if (sys_reset)
      count_r <= PMT_COUNT_RST;
    else if (wr_count)
      count_r <= pwdata[7:0];
    else if (match_evt)
      count_r <= PMT_COUNT_RST;
    else if (tmr_tick)
      count_r <= count_r + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      period_r <= PMT_PERIOD_RST;
    else if (sys_reset)
      period_r <= PMT_PERIOD_RST;
    else if (wr_en && paddr == PMT_ADDR_PERIOD)
      period_r <= pwdata[7:0];
  end

  // control write loads the fields and clears both dividers, never the count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= PMT_CTRL_RST;
    else if (sys_reset)
      ctrl_r <= PMT_CTRL_RST;
    else if (wr_ctrl)
    begin
      ctrl_r.prescale_select  <= pwdata[PMT_CTRL_PRE_LSB +: 2];
      ctrl_r.postscale_select <= pwdata[PMT_CTRL_POST_LSB +: 4];
    end
  end

  // flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_r <= 1'b0;
    else if (sys_reset)
      flag_r <= 1'b0;
    else if (post_evt)
      flag_r <= 1'b1;
    else if (wr_en && paddr == PMT_ADDR_FLAG)
      flag_r <= pwdata[PMT_FLAG_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_r  <= 1'b0;
      gie_r     <= 1'b0;
      spi_sel_r <= 1'b0;
    end
    else if (sys_reset)
    begin
      enable_r  <= 1'b0;
      gie_r     <= 1'b0;
      spi_sel_r <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == PMT_ADDR_ENABLE)
        enable_r <= pwdata[PMT_ENABLE_BIT];
      if (wr_en && paddr == PMT_ADDR_GLOBAL)
      begin
        gie_r     <= pwdata[PMT_GIE_BIT];
        spi_sel_r <= pwdata[PMT_SPI_SEL_BIT];
      end
    end
  end

  // outputs; shift clock toggles per match so one period is two matches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_out_r <= 1'b0;
      spi_clk_r   <= 1'b0;
      irq_r       <= 1'b0;
    end
    else
    begin
      match_out_r <= match_evt;
      if (!spi_sel_r)
        spi_clk_r <= 1'b0;
      else if (match_evt)
        spi_clk_r <= !spi_clk_r;
      irq_r <= flag_r && enable_r && gie_r;
    end
  end

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign match_out     = match_out_r;
  assign spi_shift_clk = spi_clk_r;
  assign irq           = irq_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_inst_rate;
    inst_tick |=> !inst_tick [*3];
  endproperty
  a_inst_rate: assert property (p_inst_rate) else $error("instruction tick too fast");
  property p_count_inc;
    tmr_tick && !match_evt && !wr_count && !sys_reset |=> count_r == $past(count_r) + 8'h01;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("count did not increment");
  property p_pre_div1;
    ctrl_r.prescale_select == PMT_PRE_DIV1 && inst_tick && !div_clr |-> tmr_tick;
  endproperty
  a_pre_div1: assert property (p_pre_div1) else $error("divide by one missed a tick");
  // a terminal check as well, so a wrong decode to divide by four is caught
  property p_pre_div16;
    tmr_tick && ctrl_r.prescale_select[1] && !div_clr |->
      pre_cnt == PMT_TERM_DIV16 ##1 !tmr_tick [*8];
  endproperty
  a_pre_div16: assert property (p_pre_div16) else $error("divide by sixteen too fast");
  property p_match_pulse;
    match_evt |=> match_out_r;
  endproperty
  a_match_pulse: assert property (p_match_pulse) else $error("match pulse missing");
  property p_reload;
    match_evt && !wr_count && !sys_reset |=> count_r == 8'h00;
  endproperty
  a_reload: assert property (p_reload) else $error("count not reloaded after match");
  property p_reset_vals;
    sys_reset |=> count_r == 8'h00 && period_r == 8'hFF;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  property p_div_clear;
    div_clr |=> pre_cnt == 4'h0 && post_cnt == 4'h0;
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("dividers not cleared");
  property p_ctrl_keeps;
    wr_ctrl && !sys_reset |=> count_r == $past(count_r);
  endproperty
  a_ctrl_keeps: assert property (p_ctrl_keeps) else $error("control write changed count");
  property p_post_ratio;
    post_evt |-> post_cnt == ctrl_r.postscale_select && match_evt;
  endproperty
  a_post_ratio: assert property (p_post_ratio) else $error("postscale ratio wrong");
  property p_flag_set;
    post_evt && !sys_reset |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_irq_gate;
    !(enable_r && gie_r) |=> !irq_r;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");
  property p_irq_pass;
    flag_r && enable_r && gie_r |=> irq_r;
  endproperty
  a_irq_pass: assert property (p_irq_pass) else $error("interrupt not forwarded");
  property p_read_count;
    rd_load && !pwrite && paddr == PMT_ADDR_COUNT |=> prdata_r[7:0] == $past(count_r);
  endproperty
  a_read_count: assert property (p_read_count) else $error("count read wrong");
  property p_sleep_hold;
    sleep && !wr_en && !sys_reset |=> count_r == $past(count_r) && period_r == $past(period_r);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");

  c_match:  cover property (match_evt);
  c_flag:   cover property (post_evt && ctrl_r.postscale_select == 4'hF);
  c_irq:    cover property ($rose(irq_r));
  c_spi:    cover property (spi_sel_r && $rose(spi_clk_r));

endmodule

//--- sim/pmt_tb.sv
// self-checking testbench of the period match timer over apb
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmt_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sys_reset;
  logic        sleep;
  logic        match_out;
  logic        spi_shift_clk;
  logic        irq;
  int          fail_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n;
  int          m;
  logic        s0;
  logic [31:0] rd;
  logic        err;
  int          divs[4] = '{1, 4, 16, 16};

  pmt_timer u_dut (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .sys_reset     (sys_reset),
    .sleep         (sleep),
    .match_out     (match_out),
    .spi_shift_clk (spi_shift_clk),
    .irq           (irq)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // whole run needs about 14k cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fail_count++;
      $display("[FAIL] %0t run did not finish", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, msg);
  endtask

  task automatic wait_match;
    do @(posedge pclk); while (match_out !== 1'b1);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sys_reset = 1'b0;
    // frozen so that reset values can be read back before counting
    sleep = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;

    rdchk(PMT_ADDR_COUNT, 32'h0000_0000, "count reset");
    rdchk(PMT_ADDR_PERIOD, 32'h0000_00FF, "period reset");
    rdchk(PMT_ADDR_CTRL, 32'h0000_0000, "control reset");
    rdchk(PMT_ADDR_FLAG, 32'h0000_0000, "flag reset");
    rdchk(PMT_ADDR_ENABLE, 32'h0000_0000, "enable reset");
    chk(32'(err), 32'h0000_0000, "mapped read error");
    rdchk(8'h18, 32'h0000_0000, "unmapped read");
    chk(32'(err), 32'h0000_0001, "unmapped error");
    $display("test reset values done");

    wr(PMT_ADDR_PERIOD, 32'h0000_00A5);
    rdchk(PMT_ADDR_PERIOD, 32'h0000_00A5, "period rw");
    wr(PMT_ADDR_COUNT, 32'h0000_003C);
    rdchk(PMT_ADDR_COUNT, 32'h0000_003C, "count rw");
    wr(PMT_ADDR_CTRL, 32'h0000_007F);
    rdchk(PMT_ADDR_CTRL, 32'h0000_007B, "control fields");
    $display("test register access done");

    sleep <= 1'b0;
    wr(PMT_ADDR_PERIOD, 32'h0000_0002);
    for (int i = 0; i < 4; i++)
    begin
      wr(PMT_ADDR_CTRL, 32'(i));
      wait_match();
      n = 0;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (match_out !== 1'b1);
      chk(32'(n), 32'(PMT_INST_DIV * divs[i] * 3), "match interval");
    end
    $display("test prescale done");

    wr(PMT_ADDR_PERIOD, 32'h0000_0014);
    wr(PMT_ADDR_ENABLE, 32'h0000_0001);
    wr(PMT_ADDR_GLOBAL, 32'h0000_0001);
    for (int k = 0; k < 16; k++)
    begin
      wr(PMT_ADDR_CTRL, 32'(k << PMT_CTRL_POST_LSB));
      // count write restarts the postscaler so the match count is exact
      wr(PMT_ADDR_COUNT, 32'h0000_0000);
      wr(PMT_ADDR_FLAG, 32'h0000_0000);
      repeat (3) @(posedge pclk);
      m = 0;
      do
      begin
        @(posedge pclk);
        if (match_out === 1'b1)
          m++;
      end
      while (irq !== 1'b1);
      chk(32'(m), 32'(k + 1), "postscale ratio");
    end
    rdchk(PMT_ADDR_FLAG, 32'h0000_0001, "flag set");
    wr(PMT_ADDR_ENABLE, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0000_0000, "irq masked by enable");
    rdchk(PMT_ADDR_FLAG, 32'h0000_0001, "flag stays latched");
    wr(PMT_ADDR_ENABLE, 32'h0000_0001);
    wr(PMT_ADDR_GLOBAL, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0000_0000, "irq masked by global");
    wr(PMT_ADDR_GLOBAL, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0000_0001, "irq restored");
    wr(PMT_ADDR_FLAG, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0000_0000, "irq after flag clear");
    $display("test postscale and interrupt done");

    wr(PMT_ADDR_GLOBAL, 32'h0000_0003);
    wait_match();
    repeat (2) @(posedge pclk);
    s0 = spi_shift_clk;
    wait_match();
    repeat (2) @(posedge pclk);
    chk(32'(spi_shift_clk), 32'(!s0), "shift clock toggle");
    wr(PMT_ADDR_GLOBAL, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk(32'(spi_shift_clk), 32'h0000_0000, "shift clock off");
    $display("test shift clock done");

    @(posedge pclk);
    sleep <= 1'b1;
    wr(PMT_ADDR_COUNT, 32'h0000_0037);
    wr(PMT_ADDR_CTRL, 32'h0000_0002);
    repeat (50) @(posedge pclk);
    rdchk(PMT_ADDR_COUNT, 32'h0000_0037, "count after control write");
    rdchk(PMT_ADDR_PERIOD, 32'h0000_0014, "period held in sleep");
    $display("test sleep done");

    @(posedge pclk);
    sys_reset <= 1'b1;
    @(posedge pclk);
    sys_reset <= 1'b0;
    rdchk(PMT_ADDR_COUNT, 32'h0000_0000, "count after device reset");
    rdchk(PMT_ADDR_PERIOD, 32'h0000_00FF, "period after device reset");
    rdchk(PMT_ADDR_CTRL, 32'h0000_0000, "control after device reset");
    // asynchronous reset in mid-run must restore the same values
    wr(PMT_ADDR_PERIOD, 32'h0000_0055);
    wr(PMT_ADDR_ENABLE, 32'h0000_0001);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(PMT_ADDR_PERIOD, 32'h0000_00FF, "period after power-on reset");
    rdchk(PMT_ADDR_ENABLE, 32'h0000_0000, "enable after power-on reset");
    sleep <= 1'b0;
    $display("test device reset done");
    wrap_up();
  end
endmodule
